/* core/strap_cfg_pkg.sv */
package strap_cfg_pkg;
    localparam int REG_W = 8;
    // bit positions in the mode registers
    localparam int MODE_EN_BIT = 6;
    localparam int MODE_QUAD_BIT = 5;
    localparam int MODE_SRC_LSB = 0;
    // bit positions in the drive register and the input termination register
    localparam int DRV_PE_LSB = 2;
    localparam int DRV_OTO_BIT = 1;
    localparam int DRV_OCL_BIT = 0;
    localparam int TERM_ON_BIT = 0;
    // forced values while straps rule, plus the zero byte, source codes and aux line count
    localparam logic QUAD_MODE_CODE = 1'h0;
    localparam logic AUX_ALWAYS_ON = 1'h1;
    localparam logic TERM_ALWAYS_ON = 1'h1;
    localparam logic [7:0] PULSE_OFF = 8'h00;
    localparam logic [7:0] REG_ZERO = 8'h00;
    localparam logic [1:0] SRC_A = 2'h0;
    localparam logic [1:0] SRC_B = 2'h1;
    localparam logic [1:0] SRC_C = 2'h2;
    localparam logic [1:0] SRC_D = 2'h3;
    localparam int AUX_LINES = 4;

    // strap pin group
    typedef struct packed {
        logic hs_enable;
        logic [1:0] source_select;
        logic equalization_level;
        logic [1:0] preemphasis_level;
        logic output_termination;
        logic output_current;
    } strap_t;

    // register image seen by the analog core
    typedef struct packed {
        logic [7:0] high_speed_mode_ctrl;
        logic [7:0] aux_mode_ctrl;
        logic [7:0] input_termination_ctrl;
        logic [7:0] term_pulse_ab;
        logic [7:0] term_pulse_cd;
        logic [7:0] equalizer_ab;
        logic [7:0] equalizer_cd;
        logic [7:0] output_drive_ctrl;
    } regs_t;
endpackage : strap_cfg_pkg

/* core/strap_pin_switch_config.sv */
// Overview of operation
// - Straps steer the settings from reset until the first serial access, then no more.
// - Strap mode forces the high-speed switching mode to quad.
// - Enable strap 0 turns high-speed channels off (standby), 1 turns them on.
// - Source strap 00/01/10/11 routes source A/B/C/D high-speed channels to the output.
// - Strap mode keeps the auxiliary switch always on in quad mode.
// - Source strap 00/01/10/11 connects aux lines of A/B/C/D to the common output.
// - Strap mode keeps every input termination connected.
// - Strap mode disables termination pulsing; both pulse registers read zero.
// - One equalization strap sets all sixteen inputs: 0 is 6 dB, 1 is 12 dB.
// - Pre-emphasis strap 00/01/10/11 gives 0/2/4/6 dB on all outputs.
// - Output termination strap 0 is off, 1 is on.
// - Output current strap 0 is 10 mA, 1 is 20 mA.
`timescale 1ns/100ps
`default_nettype none
module strap_pin_switch_config
    import strap_cfg_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire strap_t STRAP_PINS,
    input wire logic SERIAL_ACCESS,
    input wire logic [AUX_LINES-1:0] AUX_A_IN,
    input wire logic [AUX_LINES-1:0] AUX_B_IN,
    input wire logic [AUX_LINES-1:0] AUX_C_IN,
    input wire logic [AUX_LINES-1:0] AUX_D_IN,
    output var regs_t CTRL_REGS,
    output logic STRAP_ACTIVE,
    output logic [AUX_LINES-1:0] AUX_COMMON_OUTPUT
);
    strap_t strap_meta_r;
    strap_t strap_sync_r;
    logic access_meta_r;
    logic access_sync_r;
    logic strap_active_r;
    regs_t regs_r;
    regs_t regs_nxt;
    logic [AUX_LINES-1:0] aux_r;

    // pins are asynchronous; two stages before use
    always_ff @(posedge REF_CLK) begin
        strap_meta_r <= STRAP_PINS;
        strap_sync_r <= strap_meta_r;
        access_meta_r <= SERIAL_ACCESS;
        access_sync_r <= access_meta_r;
    end

    // strap window: opens at reset, closes for good on first serial access
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            strap_active_r <= 1'b1;
        end else if (access_sync_r) begin
            strap_active_r <= 1'b0;
        end
    end

    // register image built from the synchronised straps
    always_comb begin
        regs_nxt = '0;
        regs_nxt.high_speed_mode_ctrl[MODE_EN_BIT] = strap_sync_r.hs_enable;
        regs_nxt.high_speed_mode_ctrl[MODE_QUAD_BIT] = QUAD_MODE_CODE;
        regs_nxt.high_speed_mode_ctrl[MODE_SRC_LSB +: 2] = strap_sync_r.source_select;
        regs_nxt.aux_mode_ctrl[MODE_EN_BIT] = AUX_ALWAYS_ON;
        regs_nxt.aux_mode_ctrl[MODE_QUAD_BIT] = QUAD_MODE_CODE;
        regs_nxt.aux_mode_ctrl[MODE_SRC_LSB +: 2] = strap_sync_r.source_select;
        regs_nxt.input_termination_ctrl[TERM_ON_BIT] = TERM_ALWAYS_ON;
        regs_nxt.term_pulse_ab = PULSE_OFF;
        regs_nxt.term_pulse_cd = PULSE_OFF;
        regs_nxt.equalizer_ab = {REG_W{strap_sync_r.equalization_level}};
        regs_nxt.equalizer_cd = {REG_W{strap_sync_r.equalization_level}};
        regs_nxt.output_drive_ctrl[DRV_PE_LSB +: 2] = strap_sync_r.preemphasis_level;
        regs_nxt.output_drive_ctrl[DRV_OTO_BIT] = strap_sync_r.output_termination;
        regs_nxt.output_drive_ctrl[DRV_OCL_BIT] = strap_sync_r.output_current;
    end

    // copy while the window is open, freeze once it closes
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            regs_r <= '0;
            regs_r.aux_mode_ctrl[MODE_EN_BIT] <= AUX_ALWAYS_ON;
            regs_r.input_termination_ctrl[TERM_ON_BIT] <= TERM_ALWAYS_ON;
        end else if (strap_active_r && !access_sync_r) begin
            regs_r <= regs_nxt;
        end
    end

    // aux mux from the live source field; aux stays enabled even in standby
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            aux_r <= '0;
        end else begin
            case (regs_r.aux_mode_ctrl[MODE_SRC_LSB +: 2])
                SRC_A: aux_r <= AUX_A_IN;
                SRC_B: aux_r <= AUX_B_IN;
                SRC_C: aux_r <= AUX_C_IN;
                default: aux_r <= AUX_D_IN;
            endcase
        end
    end

    assign CTRL_REGS = regs_r;
    assign STRAP_ACTIVE = strap_active_r;
    assign AUX_COMMON_OUTPUT = aux_r;

    // checker helper: saturating count of edges since the window shut,
    // so a long freeze can be asserted without a long repetition
    logic [3:0] closed_cnt_r;

    // counts only while closed; reset clears it with the window
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            closed_cnt_r <= '0;
        end else if (!strap_active_r && closed_cnt_r != '1) begin
            closed_cnt_r <= closed_cnt_r + 1'b1; // saturates, never wraps
        end
    end

    // reset image: only the forced-on bits are set, nothing else;
    // these run through reset on purpose, so no disable clause
    chk_reset_hs_clear: assert property (@(posedge REF_CLK)
        RESET |=> regs_r.high_speed_mode_ctrl == REG_ZERO
        && regs_r.output_drive_ctrl == REG_ZERO)
        else $error("high-speed or drive register not cleared by reset");

    chk_reset_forced_on: assert property (@(posedge REF_CLK)
        RESET |=> regs_r.aux_mode_ctrl[MODE_EN_BIT] == AUX_ALWAYS_ON
        && regs_r.input_termination_ctrl[TERM_ON_BIT] == TERM_ALWAYS_ON)
        else $error("forced-on bits missing after reset");

    chk_reset_opens: assert property (@(posedge REF_CLK)
        RESET |=> strap_active_r)
        else $error("strap window not reopened by reset");

    chk_reset_aux_clear: assert property (@(posedge REF_CLK)
        RESET |=> aux_r == '0)
        else $error("aux output not cleared by reset");

    // pulse registers: zero at every edge, strap mode never pulses
    chk_pulse_regs_zero: assert property (@(posedge REF_CLK) disable iff (RESET)
        regs_r.term_pulse_ab == REG_ZERO && regs_r.term_pulse_cd == REG_ZERO)
        else $error("termination pulse register nonzero");

    // forced switching modes and their unused bits
    chk_quad_forced: assert property (@(posedge REF_CLK) disable iff (RESET)
        regs_r.high_speed_mode_ctrl[MODE_QUAD_BIT] == QUAD_MODE_CODE)
        else $error("high-speed mode not quad");

    chk_hs_unused_zero: assert property (@(posedge REF_CLK) disable iff (RESET)
        regs_r.high_speed_mode_ctrl[REG_W-1] == 1'b0
        && regs_r.high_speed_mode_ctrl[MODE_QUAD_BIT-1:MODE_SRC_LSB+2] == '0)
        else $error("high-speed mode spare bits set");

    chk_aux_enabled: assert property (@(posedge REF_CLK) disable iff (RESET)
        regs_r.aux_mode_ctrl[MODE_EN_BIT] == AUX_ALWAYS_ON
        && regs_r.aux_mode_ctrl[MODE_QUAD_BIT] == QUAD_MODE_CODE)
        else $error("aux switch not enabled in quad");

    chk_aux_unused_zero: assert property (@(posedge REF_CLK) disable iff (RESET)
        regs_r.aux_mode_ctrl[REG_W-1] == 1'b0
        && regs_r.aux_mode_ctrl[MODE_QUAD_BIT-1:MODE_SRC_LSB+2] == '0)
        else $error("aux mode spare bits set");

    // standby must not take the aux path down with it
    chk_standby_aux_on: assert property (@(posedge REF_CLK) disable iff (RESET)
        !regs_r.high_speed_mode_ctrl[MODE_EN_BIT] |-> regs_r.aux_mode_ctrl[MODE_EN_BIT])
        else $error("aux switch off in standby");

    // input termination stays connected
    chk_term_on: assert property (@(posedge REF_CLK) disable iff (RESET)
        regs_r.input_termination_ctrl[TERM_ON_BIT] == TERM_ALWAYS_ON)
        else $error("input termination off");

    chk_term_unused_zero: assert property (@(posedge REF_CLK) disable iff (RESET)
        regs_r.input_termination_ctrl[REG_W-1:TERM_ON_BIT+1] == '0)
        else $error("receiver settings spare bits set");

    // strap window: closes on access, stays shut, and only access shuts it
    chk_window_closes: assert property (@(posedge REF_CLK) disable iff (RESET)
        access_sync_r |=> !strap_active_r)
        else $error("strap window still open after access");

    chk_window_latch: assert property (@(posedge REF_CLK) disable iff (RESET)
        !strap_active_r |=> !strap_active_r)
        else $error("strap window reopened without reset");

    chk_window_held: assert property (@(posedge REF_CLK) disable iff (RESET)
        (strap_active_r && !access_sync_r) |=> strap_active_r)
        else $error("strap window closed without access");

    chk_cnt_closed: assert property (@(posedge REF_CLK) disable iff (RESET)
        closed_cnt_r != '0 |-> !strap_active_r)
        else $error("closed count running while window open");

    // freeze: the register image holds once the window is shut
    chk_freeze_hold: assert property (@(posedge REF_CLK) disable iff (RESET)
        (!strap_active_r || access_sync_r) |=> $stable(regs_r))
        else $error("registers changed after strap window");

    // a long freeze: the image eight edges back still matches
    chk_hold_long: assert property (@(posedge REF_CLK) disable iff (RESET)
        closed_cnt_r == '1 |-> regs_r == $past(regs_r, 8))
        else $error("registers drifted during long freeze");

    // live copy of the enable and source straps while the window is open
    chk_copy_live: assert property (@(posedge REF_CLK) disable iff (RESET)
        (strap_active_r && !access_sync_r) |=>
        regs_r.high_speed_mode_ctrl[MODE_EN_BIT] == $past(strap_sync_r.hs_enable)
        && regs_r.high_speed_mode_ctrl[MODE_SRC_LSB +: 2] == $past(strap_sync_r.source_select))
        else $error("enable or source not copied");

    chk_aux_src_copy: assert property (@(posedge REF_CLK) disable iff (RESET)
        (strap_active_r && !access_sync_r) |=>
        regs_r.aux_mode_ctrl[MODE_SRC_LSB +: 2] == $past(strap_sync_r.source_select))
        else $error("aux source not copied");

    chk_src_match: assert property (@(posedge REF_CLK) disable iff (RESET)
        regs_r.aux_mode_ctrl[MODE_SRC_LSB +: 2] ==
        regs_r.high_speed_mode_ctrl[MODE_SRC_LSB +: 2])
        else $error("aux and high-speed sources differ");

    // one equalization level for all sixteen inputs
    chk_eq_uniform: assert property (@(posedge REF_CLK) disable iff (RESET)
        regs_r.equalizer_ab == regs_r.equalizer_cd
        && (regs_r.equalizer_ab == REG_ZERO || regs_r.equalizer_ab == ~REG_ZERO))
        else $error("equalizer not uniform");

    chk_eq_copy: assert property (@(posedge REF_CLK) disable iff (RESET)
        (strap_active_r && !access_sync_r) |=>
        regs_r.equalizer_ab == {REG_W{$past(strap_sync_r.equalization_level)}})
        else $error("equalization strap not copied");

    // output drive fields and the spare bits above them
    chk_drive_copy: assert property (@(posedge REF_CLK) disable iff (RESET)
        (strap_active_r && !access_sync_r) |=>
        regs_r.output_drive_ctrl[DRV_PE_LSB +: 2] == $past(strap_sync_r.preemphasis_level)
        && regs_r.output_drive_ctrl[DRV_OTO_BIT] == $past(strap_sync_r.output_termination)
        && regs_r.output_drive_ctrl[DRV_OCL_BIT] == $past(strap_sync_r.output_current))
        else $error("drive settings not copied");

    chk_drive_unused_zero: assert property (@(posedge REF_CLK) disable iff (RESET)
        regs_r.output_drive_ctrl[REG_W-1:DRV_PE_LSB+2] == '0)
        else $error("drive register spare bits set");

    // aux routing, one check per source; the mux is a cycle behind the field
    chk_aux_route_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        regs_r.aux_mode_ctrl[MODE_SRC_LSB +: 2] == SRC_A |=> aux_r == $past(AUX_A_IN))
        else $error("aux source A not routed");

    chk_aux_route: assert property (@(posedge REF_CLK) disable iff (RESET)
        regs_r.aux_mode_ctrl[MODE_SRC_LSB +: 2] == SRC_B |=> aux_r == $past(AUX_B_IN))
        else $error("aux source B not routed");

    chk_aux_route_c: assert property (@(posedge REF_CLK) disable iff (RESET)
        regs_r.aux_mode_ctrl[MODE_SRC_LSB +: 2] == SRC_C |=> aux_r == $past(AUX_C_IN))
        else $error("aux source C not routed");

    chk_aux_route_d: assert property (@(posedge REF_CLK) disable iff (RESET)
        regs_r.aux_mode_ctrl[MODE_SRC_LSB +: 2] == SRC_D |=> aux_r == $past(AUX_D_IN))
        else $error("aux source D not routed");

    // main scenarios worth seeing at least once
    cov_freeze: cover property (@(posedge REF_CLK) disable iff (RESET)
        strap_active_r ##1 !strap_active_r);

    cov_src_d: cover property (@(posedge REF_CLK) disable iff (RESET)
        regs_r.high_speed_mode_ctrl[MODE_SRC_LSB +: 2] == SRC_D);

    cov_standby: cover property (@(posedge REF_CLK) disable iff (RESET)
        !regs_r.high_speed_mode_ctrl[MODE_EN_BIT] && strap_active_r);

    cov_eq_high: cover property (@(posedge REF_CLK) disable iff (RESET)
        regs_r.equalizer_ab == ~REG_ZERO);

    // proves the long-freeze check is not vacuous
    cov_hold_long: cover property (@(posedge REF_CLK) disable iff (RESET)
        closed_cnt_r == '1);
endmodule : strap_pin_switch_config
`default_nettype wire

/* verif/strap_board_model.sv */
`timescale 1ns/100ps
`default_nettype none
// board straps: each pin tied to a rail, the bench picks which one
module strap_board_model
    import strap_cfg_pkg::*;
(
    input wire strap_t tie_level,
    output strap_t pins
);
    // rails are static, so the pins are never left floating
    assign pins = tie_level;
endmodule : strap_board_model
`default_nettype wire

/* verif/strap_pin_switch_config_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module strap_pin_switch_config_tb
    import strap_cfg_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic serial_access = 1'b0;
    strap_t strap_level = '0;
    strap_t strap_pins;
    regs_t ctrl_regs;
    logic strap_active;
    logic [3:0] aux_out;
    int n_fail = 0;
    int compares = 0;
    always #4 ref_clk = ~ref_clk;
    strap_board_model u_strap_board_model (.tie_level(strap_level), .pins(strap_pins));
    strap_pin_switch_config u_strap_pin_switch_config (.REF_CLK(ref_clk), .RESET(reset),
        .STRAP_PINS(strap_pins), .SERIAL_ACCESS(serial_access), .AUX_A_IN(4'h3),
        .AUX_B_IN(4'h5), .AUX_C_IN(4'ha), .AUX_D_IN(4'hc), .CTRL_REGS(ctrl_regs),
        .STRAP_ACTIVE(strap_active), .AUX_COMMON_OUTPUT(aux_out));
    // register image the straps should produce; pulse registers stay zero
    function automatic regs_t expect_regs(strap_t s);
        regs_t r;
        r = '0;
        r.high_speed_mode_ctrl[MODE_EN_BIT] = s.hs_enable;
        r.high_speed_mode_ctrl[MODE_QUAD_BIT] = QUAD_MODE_CODE;
        r.high_speed_mode_ctrl[1:0] = s.source_select;
        r.aux_mode_ctrl[MODE_EN_BIT] = AUX_ALWAYS_ON;
        r.aux_mode_ctrl[1:0] = s.source_select;
        r.input_termination_ctrl[TERM_ON_BIT] = TERM_ALWAYS_ON;
        r.equalizer_ab = {8{s.equalization_level}};
        r.equalizer_cd = {8{s.equalization_level}};
        r.output_drive_ctrl = {4'h0, s.preemphasis_level, s.output_termination, s.output_current};
        return r;
    endfunction : expect_regs
    // same values the aux inputs are tied to above
    function automatic logic [63:0] expect_aux(logic [1:0] src);
        case (src)
            2'h0: return 64'h3;
            2'h1: return 64'h5;
            2'h2: return 64'ha;
            default: return 64'hc;
        endcase
    endfunction : expect_aux
    task check(input logic [63:0] seen, input logic [63:0] want);
        compares++;
        if (seen !== want) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    // inputs move 1 ns after the edge, away from sampling
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task test_done;
        if (n_fail == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    initial begin
        tick(2);
        check(ctrl_regs, 64'h0040_0100_0000_0000);
        check({63'h0, strap_active}, 64'h1);
        reset = 1'b0;
        // every strap combination, so every code of every field is seen
        for (int i = 0; i < 256; i++) begin
            strap_level = strap_t'(i[7:0]);
            tick(5);
            check(ctrl_regs, expect_regs(strap_level));
            check(ctrl_regs, expect_regs(strap_level));
            check({60'h0, aux_out}, expect_aux(strap_level.source_select));
        end
        strap_level = strap_t'(8'h5a);
        tick(5);
        serial_access = 1'b1;
        tick(1);
        serial_access = 1'b0;
        // bounded wait for the straps to lose control
        for (int w = 0; w < 8 && strap_active !== 1'b0; w++)
            tick(1);
        check({63'h0, strap_active}, 64'h0);
        if (strap_active === 1'b0) begin
            strap_level = strap_t'(~strap_level);
            tick(20);
            check(ctrl_regs, expect_regs(strap_t'(8'h5a)));
            check({63'h0, strap_active}, 64'h0);
            // a fresh reset hands control back to the straps
            reset = 1'b1;
            tick(2);
            reset = 1'b0;
            tick(5);
            check(ctrl_regs, expect_regs(strap_level));
            check({63'h0, strap_active}, 64'h1);
        end
        test_done();
    end
endmodule : strap_pin_switch_config_tb
`default_nettype wire
